/* verilog/acp_regs.svh */
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define ACP_CLK_NS        5
`define ACP_T_CONV_NS     1680
`define ACP_CONV_CYC      (`ACP_T_CONV_NS / `ACP_CLK_NS)
`define ACP_T_EOC_NS      100
`define ACP_EOC_CYC       (`ACP_T_EOC_NS / `ACP_CLK_NS)
`define ACP_T_RD_LEAD_NS  200
`define ACP_RD_LEAD_CYC   \
  ((`ACP_T_RD_LEAD_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_CONVERT_START_CYC    4
// the read strobe must outlast the driver turn-on and both synchronisers
`define ACP_RD_ACC_CYC    12
`define ACP_SCLK_HALF     16

// ****************************************************************
// word layout and pin positions
// ****************************************************************
`define ACP_RES_BITS      12
`define ACP_LEAD_ZEROS    4
`define ACP_SER_BITS      (`ACP_LEAD_ZEROS + `ACP_RES_BITS)
`define ACP_SDO_BIT       5
`define ACP_SCLK_BIT      4
`define ACP_FS_BIT        3

// ****************************************************************
// synchroniser reset values
// ****************************************************************
`define ACP_DSYNC_RST     4'he
`define ACP_HSYNC_RST     13'h1fff

`endif

/* verilog/acp_pkg.sv */
package acp_pkg;

  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_CONV,
    DEV_DONE
  } acp_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_START,
    HST_WAIT,
    HST_PREAD,
    HST_SER
  } acp_host_state_t;

endpackage

/* verilog/acp_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

interface acp_if;
  logic                     convert_start;
  logic                     rd_n;
  logic                     cs_n;
  logic                     eoc_n;
  logic [`ACP_RES_BITS-1:0] dev_db_o;
  logic [`ACP_RES_BITS-1:0] dev_db_oe_n;
  logic                     dev_sdo;
  logic                     dev_ser;
  logic [`ACP_RES_BITS-1:0] host_db_o;
  logic [`ACP_RES_BITS-1:0] host_db_oe_n;
  logic [`ACP_RES_BITS-1:0] db;
  logic                     result_bit5_or_serial_out;
  logic                     result_bit4_or_shift_clock;
  logic                     result_bit3_or_frame_sync;
  logic                     sclk;
  logic                     frame_sync_n;

  // ****************************************************************
  // wire resolution, undriven lines pulled high
  // ****************************************************************
  for (genvar i = 0; i < `ACP_RES_BITS; i++)
  begin : g_res
    assign db[i] = !dev_db_oe_n[i] ?
                     ((i == `ACP_SDO_BIT && dev_ser) ? dev_sdo
                                                     : dev_db_o[i]) :
                   !host_db_oe_n[i] ? host_db_o[i] : 1'b1;
  end

  assign result_bit5_or_serial_out  = db[`ACP_SDO_BIT];
  assign result_bit4_or_shift_clock = db[`ACP_SCLK_BIT];
  assign result_bit3_or_frame_sync  = db[`ACP_FS_BIT];
  assign sclk                       = result_bit4_or_shift_clock;
  assign frame_sync_n               = result_bit3_or_frame_sync;

  modport dev (
    input  convert_start,
    input  rd_n,
    input  cs_n,
    input  db,
    input  sclk,
    input  frame_sync_n,
    output eoc_n,
    output dev_db_o,
    output dev_db_oe_n,
    output dev_sdo,
    output dev_ser
  );

  modport host (
    output convert_start,
    output rd_n,
    output cs_n,
    output host_db_o,
    output host_db_oe_n,
    input  eoc_n,
    input  db
  );
endinterface

`default_nettype wire

/* verilog/acp_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

module acp_dev
  import acp_pkg::*;
#(
  parameter int RES_W    = `ACP_RES_BITS,
  parameter int CONV_CYC = `ACP_CONV_CYC,
  parameter int EOC_CYC  = `ACP_EOC_CYC
)(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  acp_if.dev                    lnk,
  input  wire logic [RES_W-1:0] sar_code_i,
  input  wire logic             par_sel_i,
  output logic                  hold_o,
  output logic                  busy_o,
  output logic      [RES_W-1:0] result_o
);

  localparam int NSYNC  = 4;
  localparam int SER_W  = `ACP_SER_BITS;
  localparam int CNT_W  = 16;
  localparam int BCNT_W = 5;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // order: {select, chip select, read, convert start}
  logic [NSYNC-1:0] in_raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] flt_reg;
  localparam logic [NSYNC-1:0] SYNC_RST = `ACP_DSYNC_RST;

  assign in_raw = {par_sel_i, lnk.cs_n, lnk.rd_n, lnk.convert_start};

  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        s1_reg[i]  <= SYNC_RST[i];
        s2_reg[i]  <= SYNC_RST[i];
        s3_reg[i]  <= SYNC_RST[i];
        flt_reg[i] <= SYNC_RST[i];
      end
      else
      begin
        s1_reg[i] <= in_raw[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        // a change counts only once two stages agree
        if (s2_reg[i] == s3_reg[i])
          flt_reg[i] <= s3_reg[i];
      end
    end
  end

  logic cv_lvl;
  logic rd_act;
  logic par_mode;
  logic cv_prev_reg;
  logic cv_rise;

  assign cv_lvl   = flt_reg[0];
  assign rd_act   = !flt_reg[1] && !flt_reg[2];
  assign par_mode = flt_reg[3];

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cv_prev_reg <= 1'b0;
    else
      cv_prev_reg <= cv_lvl;
  end

  assign cv_rise = cv_lvl && !cv_prev_reg;

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  // a start edge seen during a conversion or its done pulse is dropped
  acp_dev_state_t   state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             conv_end;
  logic             eoc_end;

  assign conv_end = (state_reg == DEV_CONV) &&
                    (cnt_reg == CNT_W'(CONV_CYC - 1));
  assign eoc_end  = (state_reg == DEV_DONE) &&
                    (cnt_reg == CNT_W'(EOC_CYC - 1));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= DEV_IDLE;
      cnt_reg   <= '0;
    end
    else
    begin
      case (state_reg)
        DEV_IDLE:
        begin
          cnt_reg <= '0;
          if (cv_rise)
            state_reg <= DEV_CONV;
        end
        DEV_CONV:
        begin
          if (conv_end)
          begin
            state_reg <= DEV_DONE;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 16'h1;
        end
        DEV_DONE:
        begin
          if (eoc_end)
          begin
            state_reg <= DEV_IDLE;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 16'h1;
        end
        default:
        begin
          state_reg <= DEV_IDLE;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  // track/hold control
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      hold_o <= 1'b0;
    else if (state_reg == DEV_IDLE && cv_rise)
      hold_o <= 1'b1;
    else if (conv_end)
      hold_o <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state_reg == DEV_IDLE) ? cv_rise : !eoc_end;
  end

  // ****************************************************************
  // result register and done pulse
  // ****************************************************************
  logic [RES_W-1:0] result_reg;

  // the core delivers offset binary; flipping the sign bit gives
  // two's complement
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      result_reg <= '0;
    else if (conv_end)
      result_reg <= {~sar_code_i[RES_W-1], sar_code_i[RES_W-2:0]};
  end

  assign result_o = result_reg;

  // loaded on the same edge as the result, so the result and the pulse change together
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lnk.eoc_n <= 1'b1;
    else if (conv_end)
      lnk.eoc_n <= 1'b0;
    else if (eoc_end)
      lnk.eoc_n <= 1'b1;
  end

  // ****************************************************************
  // parallel drivers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lnk.dev_db_o    <= '0;
      lnk.dev_db_oe_n <= '1;
      lnk.dev_ser     <= 1'b0;
    end
    else
    begin
      lnk.dev_db_o <= result_reg;
      lnk.dev_ser  <= !par_mode;
      for (int i = 0; i < RES_W; i++)
      begin
        if (!par_mode && i == `ACP_SDO_BIT)
          lnk.dev_db_oe_n[i] <= 1'b0;
        else
          lnk.dev_db_oe_n[i] <= !(par_mode && rd_act);
      end
    end
  end

  // ****************************************************************
  // serial shifter on the shift clock
  // ****************************************************************
  // the result word crosses quasi-statically: it changes only at a
  // conversion end, which the host keeps away from a frame; the frame
  // sync clears this side since the shift clock stops between frames
  logic [SER_W-1:0]  word;
  logic [SER_W-1:0]  sr_reg;
  logic [BCNT_W-1:0] bcnt_reg;

  assign word = {{`ACP_LEAD_ZEROS{1'b0}}, result_reg};

  always_ff @(posedge lnk.sclk or posedge lnk.frame_sync_n
              or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sr_reg      <= '0;
      bcnt_reg    <= '0;
      lnk.dev_sdo <= 1'b0;
    end
    else if (lnk.frame_sync_n)
    begin
      sr_reg      <= '0;
      bcnt_reg    <= '0;
      lnk.dev_sdo <= 1'b0;
    end
    else if (bcnt_reg == 5'h0)
    begin
      lnk.dev_sdo <= word[SER_W-1];
      sr_reg      <= {word[SER_W-2:0], 1'b0};
      bcnt_reg    <= 5'h1;
    end
    else if (bcnt_reg < BCNT_W'(SER_W))
    begin
      lnk.dev_sdo <= sr_reg[SER_W-1];
      sr_reg      <= {sr_reg[SER_W-2:0], 1'b0};
      bcnt_reg    <= bcnt_reg + 5'h1;
    end
    else
      lnk.dev_sdo <= 1'b0;
  end

endmodule

`default_nettype wire

/* verilog/acp_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

module acp_host
  import acp_pkg::*;
#(
  parameter int RES_W      = `ACP_RES_BITS,
  parameter int CONVERT_START_CYC = `ACP_CONVERT_START_CYC,
  parameter int RD_ACC_CYC = `ACP_RD_ACC_CYC,
  parameter int RD_LEAD    = `ACP_RD_LEAD_CYC,
  parameter int SCLK_HALF  = `ACP_SCLK_HALF
)(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  acp_if.host                   lnk,
  input  wire logic             start_i,
  input  wire logic             par_sel_i,
  output logic                  ready_o,
  output logic                  valid_o,
  output logic      [RES_W-1:0] data_o
);

  localparam int NSYNC = RES_W + 1;
  localparam int SER_W = `ACP_SER_BITS;
  localparam int CNT_W = 16;
  localparam logic [NSYNC-1:0] SYNC_RST = `ACP_HSYNC_RST;

  // ****************************************************************
  // pin synchronisers: {done, data bus}
  // ****************************************************************
  logic [NSYNC-1:0] in_raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] flt_reg;

  assign in_raw = {lnk.eoc_n, lnk.db};

  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        s1_reg[i]  <= SYNC_RST[i];
        s2_reg[i]  <= SYNC_RST[i];
        s3_reg[i]  <= SYNC_RST[i];
        flt_reg[i] <= SYNC_RST[i];
      end
      else
      begin
        s1_reg[i] <= in_raw[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i])
          flt_reg[i] <= s3_reg[i];
      end
    end
  end

  logic eoc_prev_reg;
  logic eoc_fall;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      eoc_prev_reg <= 1'b1;
    else
      eoc_prev_reg <= flt_reg[RES_W];
  end

  assign eoc_fall = eoc_prev_reg && !flt_reg[RES_W];

  // ****************************************************************
  // sequencer
  // ****************************************************************
  acp_host_state_t  state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] lead_reg;
  logic [4:0]       bits_reg;
  logic [SER_W-1:0] shin_reg;
  logic             sclk_reg;
  logic             fs_n_reg;
  logic             ser_drv_reg;
  logic             lead_ok;
  logic             half_end;

  // a new start waits until the read strobe has led it enough
  assign lead_ok  = (lead_reg >= CNT_W'(RD_LEAD));
  assign half_end = (cnt_reg == CNT_W'(SCLK_HALF - 1));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lead_reg <= CNT_W'(RD_LEAD);
    else if (state_reg == HST_WAIT && eoc_fall && par_sel_i)
      lead_reg <= '0;
    else if (!lead_ok)
      lead_reg <= lead_reg + 16'h1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg         <= HST_IDLE;
      cnt_reg           <= '0;
      bits_reg          <= '0;
      shin_reg          <= '0;
      sclk_reg          <= 1'b0;
      fs_n_reg          <= 1'b1;
      lnk.convert_start <= 1'b0;
      lnk.rd_n          <= 1'b1;
      lnk.cs_n          <= 1'b1;
      valid_o           <= 1'b0;
      data_o            <= '0;
    end
    else
    begin
      valid_o <= 1'b0;
      case (state_reg)
        HST_IDLE:
        begin
          cnt_reg <= '0;
          if (start_i && lead_ok)
          begin
            lnk.convert_start <= 1'b1;
            state_reg         <= HST_START;
          end
        end
        HST_START:
        begin
          if (cnt_reg == CNT_W'(CONVERT_START_CYC - 1))
          begin
            lnk.convert_start <= 1'b0;
            cnt_reg           <= '0;
            state_reg         <= HST_WAIT;
          end
          else
            cnt_reg <= cnt_reg + 16'h1;
        end
        HST_WAIT:
        begin
          cnt_reg  <= '0;
          bits_reg <= '0;
          if (eoc_fall && par_sel_i)
          begin
            lnk.rd_n  <= 1'b0;
            lnk.cs_n  <= 1'b0;
            state_reg <= HST_PREAD;
          end
          else if (eoc_fall)
          begin
            fs_n_reg  <= 1'b0;
            state_reg <= HST_SER;
          end
        end
        HST_PREAD:
        begin
          if (cnt_reg == CNT_W'(RD_ACC_CYC - 1))
          begin
            data_o    <= flt_reg[RES_W-1:0];
            valid_o   <= 1'b1;
            lnk.rd_n  <= 1'b1;
            lnk.cs_n  <= 1'b1;
            state_reg <= HST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 16'h1;
        end
        HST_SER:
        begin
          cnt_reg <= half_end ? '0 : cnt_reg + 16'h1;
          if (half_end)
          begin
            sclk_reg <= !sclk_reg;
            if (sclk_reg)
            begin
              // falling edge: take the bit the rising edge launched
              shin_reg <= {shin_reg[SER_W-2:0],
                           flt_reg[`ACP_SDO_BIT]};
              bits_reg <= bits_reg + 5'h1;
              if (bits_reg == 5'(SER_W - 1))
              begin
                data_o    <= {shin_reg[RES_W-2:0],
                              flt_reg[`ACP_SDO_BIT]};
                valid_o   <= 1'b1;
                fs_n_reg  <= 1'b1;
                state_reg <= HST_IDLE;
              end
            end
          end
        end
        default:
          state_reg <= HST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ser_drv_reg <= 1'b0;
      ready_o     <= 1'b0;
    end
    else
    begin
      ser_drv_reg <= !par_sel_i;
      ready_o     <= (state_reg == HST_IDLE) && lead_ok;
    end
  end

  always_comb
  begin
    lnk.host_db_o                   = '0;
    lnk.host_db_oe_n                = '1;
    lnk.host_db_o[`ACP_SCLK_BIT]    = sclk_reg;
    lnk.host_db_o[`ACP_FS_BIT]      = fs_n_reg;
    lnk.host_db_oe_n[`ACP_SCLK_BIT] = !ser_drv_reg;
    lnk.host_db_oe_n[`ACP_FS_BIT]   = !ser_drv_reg;
  end

endmodule

`default_nettype wire

/* dv/acp_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

module acp_link_props #(
  parameter int EOC_CYC = `ACP_EOC_CYC,
  parameter int RD_LEAD = `ACP_RD_LEAD_CYC
)(
  input wire logic                     clk_i,
  input wire logic                     rst_b_i,
  input wire logic                     convert_start,
  input wire logic                     rd_n,
  input wire logic                     cs_n,
  input wire logic                     eoc_n,
  input wire logic [`ACP_RES_BITS-1:0] dev_db_oe_n,
  input wire logic                     dev_sdo,
  input wire logic                     dev_ser,
  input wire logic                     sclk,
  input wire logic                     frame_sync_n
);
  // ********
  // helper counters
  // ********
  logic [7:0] low_cnt_reg;
  logic [7:0] rd_age_reg;
  logic [4:0] bit_cnt_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      low_cnt_reg <= 8'h00;
    else if (!eoc_n)
      low_cnt_reg <= low_cnt_reg + 8'h01;
    else
      low_cnt_reg <= 8'h00;
  end

  // saturates so the first start after reset counts as well clear of a read
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_age_reg <= 8'hff;
    else if ($fell(rd_n))
      rd_age_reg <= 8'h00;
    else if (rd_age_reg != 8'hff)
      rd_age_reg <= rd_age_reg + 8'h01;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bit_cnt_reg <= 5'h00;
    else if (frame_sync_n)
      bit_cnt_reg <= 5'h00;
    else if ($rose(sclk) && bit_cnt_reg != 5'h1f)
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end

  // ********
  // properties
  // ********
  eoc_len_a: assert property (
    $rose(eoc_n) |-> low_cnt_reg == 8'(EOC_CYC))
    else $error("done pulse length wrong");
  conv_done_a: assert property (
    $rose(convert_start) |-> ##[20:40] $fell(eoc_n))
    else $error("no done pulse after start");
  start_len_a: assert property (
    $rose(convert_start) |-> convert_start[*4] ##1 !convert_start)
    else $error("start pulse shape wrong");
  read_lead_a: assert property (
    $rose(convert_start) |-> rd_age_reg >= 8'(RD_LEAD - 1))
    else $error("start too soon after read");
  oe_off_a: assert property (
    (rd_n || cs_n)[*8] |-> (dev_db_oe_n | 12'h020) == 12'hfff)
    else $error("data drivers on without read");
  oe_on_a: assert property (
    (!rd_n && !cs_n && !dev_ser)[*7] |-> dev_db_oe_n == 12'h000)
    else $error("data drivers off during read");
  ser_pins_a: assert property (
    dev_ser[*3] |-> dev_db_oe_n == 12'hfdf)
    else $error("serial pin enables wrong");
  lead_zero_a: assert property (
    $rose(sclk) && !frame_sync_n && bit_cnt_reg < 5'h04 |-> !dev_sdo)
    else $error("leading serial bit not zero");
  sdo_edge_a: assert property (
    $changed(dev_sdo) |-> $rose(sclk) || $rose(frame_sync_n))
    else $error("serial data moved off clock rise");
  // in parallel mode bit 3 carries data, so frames exist only in serial mode
  frame_len_a: assert property (
    $rose(frame_sync_n) && dev_ser |-> bit_cnt_reg == 5'h10)
    else $error("frame not sixteen clocks");
  sync_low_clk_a: assert property (
    $changed(frame_sync_n) && dev_ser |-> !sclk)
    else $error("frame sync moved with clock high");

  cover property ($fell(eoc_n));
  cover property (dev_db_oe_n == 12'h000);
  cover property ($rose(frame_sync_n));
endmodule

`default_nettype wire

/* dv/adc_conversion_output_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

module adc_conversion_output_port_test;
  localparam logic [11:0] CODES [5] =
    '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c};

  logic        clk_i;
  logic        rst_b_i;
  logic        start;
  logic        par_sel;
  logic        ready;
  logic        valid;
  logic        hold;
  logic        busy;
  logic [11:0] sar_code;
  logic [11:0] data;
  logic [11:0] result;
  logic [11:0] par_seen;
  logic [15:0] ser_sh;
  logic [15:0] ser_word;
  int          ser_cnt;
  int          err_total;
  int          tests_run;

  acp_if link ();

  acp_dev #(.CONV_CYC(20)) acp_dev_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(link), .sar_code_i(sar_code),
    .par_sel_i(par_sel), .hold_o(hold), .busy_o(busy), .result_o(result));

  acp_host acp_host_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(link), .start_i(start),
    .par_sel_i(par_sel), .ready_o(ready), .valid_o(valid), .data_o(data));

  acp_link_props acp_link_props_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .convert_start(link.convert_start),
    .rd_n(link.rd_n), .cs_n(link.cs_n), .eoc_n(link.eoc_n),
    .dev_db_oe_n(link.dev_db_oe_n), .dev_sdo(link.dev_sdo),
    .dev_ser(link.dev_ser), .sclk(link.sclk),
    .frame_sync_n(link.frame_sync_n));

  always #2.5 clk_i = ~clk_i;

  // ********
  // wire monitors
  // ********
  always @(posedge clk_i)
    if (link.dev_db_oe_n === 12'h000) par_seen <= link.db;
  // preset to ones so a short frame cannot pass
  // sync rises on the same edge as the last clock fall, so bits are
  // counted instead of waiting for the sync to rise
  always @(negedge link.frame_sync_n)
  begin
    ser_sh  = 16'hffff;
    ser_cnt = 0;
  end
  always @(negedge link.sclk)
    if (ser_cnt < 16)
    begin
      ser_sh  = {ser_sh[14:0], link.db[5]};
      ser_cnt = ser_cnt + 1;
      if (ser_cnt == 16)
        ser_word = ser_sh;
    end

  // ********
  // scenarios
  // ********
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic convert(input logic [11:0] code);
    logic [11:0] exp;
    int          n;
    exp = {~code[11], code[10:0]};
    par_seen = 12'hxxx;
    ser_word = 16'hffff;
    sar_code = code;
    for (n = 0; n < 200 && ready !== 1'b1; n++) @(negedge clk_i);
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
    for (n = 0; n < 20 && hold !== 1'b1; n++) @(negedge clk_i);
    check("hold busy", 16'h0003, {14'h0, hold, busy});
    for (n = 0; n < 2000 && valid !== 1'b1; n++) @(negedge clk_i);
    check("valid", 16'h0001, {15'h0, valid});
    check("data", {4'h0, exp}, {4'h0, data});
    check("result", {4'h0, exp}, {4'h0, result});
    repeat (40) @(negedge clk_i);
    check("idle status", 16'h0000, {14'h0, hold, busy});
    if (par_sel)
      check("bus word", {4'h0, exp}, {4'h0, par_seen});
    else
      check("serial word", {4'h0, exp}, ser_word);
  endtask

  task automatic idle_par();
    check("idle bus", 16'h0fff, {4'h0, link.db});
    check("done idle", 16'h0001, {15'h0, link.eoc_n});
  endtask

  task automatic idle_ser();
    check("serial pins", 16'h0fff, {4'h0, link.db | 12'h038});
    check("clock sync idle", 16'h0008, {4'h0, link.db & 12'h018});
  endtask

  task automatic run_codes();
    foreach (CODES[i]) convert(CODES[i]);
  endtask

  task automatic hold_result();
    convert(12'h35a);
    sar_code = 12'hca5;
    repeat (100) @(negedge clk_i);
    check("held result", 16'h0b5a, {4'h0, result});
    idle_par();
  endtask

  task automatic mode_switch(input logic par);
    par_sel = par;
    repeat (20) @(negedge clk_i);
    if (par)
      idle_par();
    else
      idle_ser();
    convert(12'h3c7);
  endtask

  task automatic end_sim();
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    end_sim();
  end

  initial
  begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    start = 1'b0;
    par_sel = 1'b1;
    sar_code = 12'h000;
    err_total = 0;
    tests_run = 0;
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (10) @(negedge clk_i);
    idle_par();
    run_codes();
    hold_result();
    mode_switch(1'b0);
    run_codes();
    mode_switch(1'b1);
    end_sim();
  end
endmodule

`default_nettype wire
